// File: eeprom_pkg.sv
// Shared constants for the serial EEPROM command logic
package eeprom_pkg;

  // Opcodes with a fixed encoding
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;

  // Status register bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_WR_LATCH = 1;
  localparam int ST_PROT_LOW = 2;
  localparam int ST_PROT_HIGH = 3;
  localparam int ST_LOCK = 4;
  localparam int ST_IDSEL = 6;
  localparam int ST_PINEN = 7;

  // Bits a write-status command may change, and the value after reset
  localparam logic [7:0] STATUS_WR_MASK = 8'hDC;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Frame lengths in serial clock cycles
  localparam logic [4:0] BITS_OPCODE = 5'h08;
  localparam logic [4:0] BITS_STATUS_WRITE = 5'h10;
  localparam logic [4:0] BITS_READ_HEADER = 5'h18;
  localparam logic [4:0] BITS_SATURATE = 5'h1F;

  // Array geometry
  localparam int MAIN_ADDR_W = 15;
  localparam int ID_ADDR_W = 6;

  // Self-timed write cycle
  localparam int CLK_PERIOD_NS = 8;
  localparam int WRITE_TIME_NS = 5000;
  localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int WRITE_CNT_W = 16;

  // Phases of one frame on the link
  typedef enum logic [2:0] {
    PH_OPCODE = 3'b000,
    PH_ADDR = 3'b001,
    PH_WDATA = 3'b010,
    PH_MEM = 3'b011,
    PH_STAT = 3'b100,
    PH_IDLE = 3'b101
  } phase_t;

endpackage

// File: eeprom_store.sv
// Byte store for the main array and the identification page
`timescale 1ns/1ns
module eeprom_store #(
  parameter int ADDR_W = 15,
  parameter int ID_W = 6
) (
  input wire logic clkWr,
  input wire logic fillValid,
  input wire logic fillId,
  input wire logic [ADDR_W-1:0] fillAddr,
  input wire logic [7:0] fillData,
  input wire logic rdId,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [7:0] rdData
);

  logic [7:0] mainMem [2**ADDR_W];
  logic [7:0] idMem [2**ID_W];

  // Loading port on the system clock
  always_ff @(posedge clkWr) begin
    if (fillValid && fillId) begin
      idMem[fillAddr[ID_W-1:0]] <= fillData;
    end
    if (fillValid && !fillId) begin
      mainMem[fillAddr] <= fillData;
    end
  end

  // Read is combinational so a byte is ready by the next falling edge
  assign rdData = rdId ? idMem[rdAddr[ID_W-1:0]] : mainMem[rdAddr];

endmodule

// File: eeprom_spi.sv
// Serial EEPROM command, status and read logic behind the SPI pins
`timescale 1ns/1ns
module eeprom_spi #(
  parameter logic [7:0] OP_WRITE_ENABLE = 8'h06,
  parameter logic [7:0] OP_WRITE_DISABLE = 8'h04
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic serialClk,
  input wire logic chipSelN,
  input wire logic serialIn,
  input wire logic holdN,
  input wire logic wpN,
  input wire logic fillValid,
  input wire logic fillId,
  input wire logic [eeprom_pkg::MAIN_ADDR_W-1:0] fillAddr,
  input wire logic [7:0] fillData,
  output logic serialOut,
  output logic serialOutOe,
  output logic [7:0] statusReg
);
  import eeprom_pkg::*;

  // Exact-length check of a finished frame
  function automatic logic lenIs(input logic [4:0] got, input logic [4:0] want);
    return got == want;
  endfunction

  // Result of a committed status write
  function automatic logic [7:0] applyStatus(input logic [7:0] cur, input logic [7:0] req);
    logic [7:0] nxt;
    nxt = (cur & ~STATUS_WR_MASK) | (req & STATUS_WR_MASK);
    if (req[ST_IDSEL] && req[ST_LOCK]) begin
      nxt[ST_IDSEL] = cur[ST_IDSEL];
      nxt[ST_LOCK] = cur[ST_LOCK];
    end
    nxt[ST_LOCK] = nxt[ST_LOCK] | cur[ST_LOCK];
    nxt[ST_BUSY] = 1'b0;
    nxt[ST_WR_LATCH] = 1'b0;
    return nxt;
  endfunction

  logic linkAlive;
  logic frameEnd;
  logic started;
  phase_t phase;
  logic [4:0] frameBits;
  logic [4:0] cnt;
  logic [15:0] inShift;
  logic [7:0] opcode;
  logic [7:0] nextOpcode;
  logic [7:0] wrData;
  logic frameTog;
  logic [2:0] byteBit;
  logic [MAIN_ADDR_W-1:0] readAddr;
  logic idMode;
  logic drvReq;
  logic [7:0] statA;
  logic [7:0] statB;
  logic [7:0] outShift;
  logic [7:0] rdData;
  logic [7:0] srcByte;
  logic [4:0] syncA;
  logic [4:0] syncB;
  logic csPrev;
  logic wpPrev;
  logic csRise;
  logic wpFall;
  logic seenTog;
  logic newFrame;
  logic wpAbort;
  logic pinLock;
  logic [7:0] pendByte;
  logic [WRITE_CNT_W-1:0] wcnt;

  ////////////////////////////////////////////////////////////////////////
  // Byte store

  eeprom_store #(
    .ADDR_W(MAIN_ADDR_W),
    .ID_W(ID_ADDR_W)
  ) store (
    .clkWr(clk_sys),
    .fillValid(fillValid),
    .fillId(fillId),
    .fillAddr(fillAddr),
    .fillData(fillData),
    .rdId(idMode),
    .rdAddr(readAddr),
    .rdData(rdData)
  );

  ////////////////////////////////////////////////////////////////////////
  // Link domain, clocked by the serial clock

  // Frame state is cleared by select high or by system reset
  assign frameEnd = chipSelN | ~linkAlive;
  assign cnt = started ? frameBits : 5'h00;
  assign nextOpcode = {inShift[6:0], serialIn};

  // Frame record kept after select rises for the commit logic
  always_ff @(posedge serialClk or negedge linkAlive) begin
    if (!linkAlive) begin
      frameBits <= 5'h00;
      inShift <= 16'h0000;
      opcode <= 8'h00;
      wrData <= 8'h00;
      frameTog <= 1'b0;
    end else if (holdN) begin
      frameBits <= (cnt == BITS_SATURATE) ? cnt : cnt + 5'h01;
      inShift <= {inShift[14:0], serialIn};
      if (cnt == BITS_OPCODE - 5'h01) begin
        opcode <= nextOpcode;
      end
      if (cnt == BITS_STATUS_WRITE - 5'h01) begin
        wrData <= nextOpcode;
      end
      if (!started) begin
        frameTog <= ~frameTog;
      end
    end
  end

  // Status snapshot carried into the link domain
  always_ff @(posedge serialClk or negedge linkAlive) begin
    if (!linkAlive) begin
      statA <= STATUS_RESET;
      statB <= STATUS_RESET;
    end else begin
      statA <= statusReg;
      statB <= statA;
    end
  end

  // Command decode and read pointer, sampled on rising edges
  always_ff @(posedge serialClk or posedge frameEnd) begin
    if (frameEnd) begin
      started <= 1'b0;
      phase <= PH_OPCODE;
      byteBit <= 3'h0;
      readAddr <= '0;
      idMode <= 1'b0;
      drvReq <= 1'b0;
    end else if (holdN) begin
      started <= 1'b1;
      unique case (phase)
        PH_OPCODE: begin
          if (cnt == BITS_OPCODE - 5'h01) begin
            if (nextOpcode == OP_READ_STATUS) begin
              phase <= PH_STAT;
              drvReq <= 1'b1;
            end else if (nextOpcode == OP_READ && !statB[ST_BUSY]) begin
              phase <= PH_ADDR;
              idMode <= statB[ST_IDSEL];
            end else if (nextOpcode == OP_WRITE_STATUS) begin
              phase <= PH_WDATA;
            end else begin
              phase <= PH_IDLE;
            end
          end
        end
        PH_ADDR: begin
          if (cnt == BITS_READ_HEADER - 5'h01) begin
            readAddr <= {inShift[13:0], serialIn};
            phase <= PH_MEM;
            drvReq <= 1'b1;
          end
        end
        PH_MEM: begin
          byteBit <= byteBit + 3'h1;
          if (byteBit == 3'h7) begin
            if (idMode) begin
              readAddr[ID_ADDR_W-1:0] <= readAddr[ID_ADDR_W-1:0] + 6'h01;
            end else begin
              readAddr <= readAddr + 15'h0001;
            end
          end
        end
        PH_STAT: begin
          byteBit <= byteBit + 3'h1;
        end
        PH_WDATA: begin
          if (cnt == BITS_STATUS_WRITE - 5'h01) begin
            phase <= PH_IDLE;
          end
        end
        PH_IDLE: begin
        end
      endcase
    end
  end

  // Byte source: full status register even while busy
  assign srcByte = (phase == PH_STAT) ? statB : rdData;

  // Output shifter, changing on falling edges
  always_ff @(negedge serialClk or posedge frameEnd) begin
    if (frameEnd) begin
      serialOut <= 1'b0;
      outShift <= 8'h00;
    end else if (holdN && (phase == PH_MEM || phase == PH_STAT)) begin
      if (byteBit == 3'h0) begin
        serialOut <= srcByte[7];
        outShift <= {srcByte[6:0], 1'b0};
      end else begin
        serialOut <= outShift[7];
        outShift <= {outShift[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // System domain

  // Release of the link domain after reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      linkAlive <= 1'b0;
    end else begin
      linkAlive <= 1'b1;
    end
  end

  // Two-stage synchronisers for pins and link levels
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      syncA <= 5'h1C;
      syncB <= 5'h1C;
    end else begin
      syncA <= {chipSelN, wpN, holdN, drvReq, frameTog};
      syncB <= syncA;
    end
  end

  // Edge history of the synchronised pins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      csPrev <= 1'b1;
      wpPrev <= 1'b1;
      seenTog <= 1'b0;
    end else begin
      csPrev <= syncB[4];
      wpPrev <= syncB[3];
      if (csRise) begin
        seenTog <= syncB[0];
      end
    end
  end

  assign csRise = syncB[4] & ~csPrev;
  assign wpFall = ~syncB[3] & wpPrev;
  assign newFrame = syncB[0] != seenTog;
  assign pinLock = statusReg[ST_PINEN] & ~syncB[3];

  // Output enable: driving, not held, still selected
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      serialOutOe <= 1'b0;
    end else begin
      serialOutOe <= syncB[1] & syncB[2] & ~syncB[4];
    end
  end

  // Pin falling during a selected frame spoils a status write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wpAbort <= 1'b0;
    end else if (csRise) begin
      wpAbort <= 1'b0;
    end else if (!syncB[4] && wpFall && statusReg[ST_PINEN]) begin
      wpAbort <= 1'b1;
    end
  end

  // Write cycle timer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wcnt <= '0;
    end else if (!statusReg[ST_BUSY]) begin
      wcnt <= WRITE_CNT_W'(WRITE_CYCLES - 1);
    end else if (wcnt != '0) begin
      wcnt <= wcnt - 1'b1;
    end
  end

  // Status register and commit of finished frames
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      statusReg <= STATUS_RESET;
      pendByte <= 8'h00;
    end else if (statusReg[ST_BUSY]) begin
      if (wcnt == '0) begin
        statusReg <= applyStatus(statusReg, pendByte);
      end
    end else if (csRise && newFrame) begin
      if (opcode == OP_WRITE_ENABLE && lenIs(frameBits, BITS_OPCODE)) begin
        statusReg[ST_WR_LATCH] <= 1'b1;
      end else if (opcode == OP_WRITE_DISABLE && lenIs(frameBits, BITS_OPCODE)) begin
        statusReg[ST_WR_LATCH] <= 1'b0;
      end else if (opcode == OP_WRITE_STATUS && lenIs(frameBits, BITS_STATUS_WRITE)) begin
        if (statusReg[ST_WR_LATCH] && !pinLock && !wpAbort) begin
          pendByte <= wrData;
          statusReg[ST_BUSY] <= 1'b1;
        end
      end else if (opcode == OP_READ && frameBits >= BITS_READ_HEADER) begin
        statusReg[ST_IDSEL] <= 1'b0;
      end else if (opcode == OP_WRITE && frameBits >= BITS_READ_HEADER) begin
        statusReg[ST_IDSEL] <= 1'b0;
      end
    end
  end

endmodule

// File: eeprom_spi_sva.sv
// Concurrent checks on the EEPROM command logic ports
`timescale 1ns/1ns
module eeprom_spi_sva (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic chipSelN,
  input wire logic holdN,
  input wire logic serialOutOe,
  input wire logic [7:0] statusReg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  int busyCnt;

  ////////////////////////////////////////////////////////////////////////
  // Length of the current write cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !statusReg[0]) begin
      busyCnt <= 0;
    end else begin
      busyCnt <= busyCnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port relations
  AST_RESET_IDLE: assert property ($rose(rst_n) |-> statusReg == 8'h00 && !serialOutOe)
    else $error("status or output enable not idle after reset");
  AST_SELECT_OFF: assert property (chipSelN [*4] |-> !serialOutOe)
    else $error("output enabled while deselected");
  AST_HOLD_OFF: assert property (!holdN [*4] |-> !serialOutOe)
    else $error("output enabled during hold");
  AST_STATUS_AT_END: assert property (
    $changed({statusReg[7], statusReg[5:2]}) |-> $fell(statusReg[0]))
    else $error("status bits changed outside a write completion");
  AST_BUSY_SPAN: assert property ($fell(statusReg[0]) |-> busyCnt inside {[615:635]})
    else $error("write cycle length wrong");
  AST_BUSY_MAX: assert property (busyCnt <= 640)
    else $error("busy flag stuck");
  AST_WEL_CLEAR: assert property ($fell(statusReg[0]) |-> !statusReg[1])
    else $error("write enable latch kept after write");
  AST_COMMIT_CS: assert property ($rose(statusReg[0]) |-> chipSelN && $past(chipSelN, 2))
    else $error("write cycle started while selected");
  AST_BIT5_ZERO: assert property (statusReg[5] == 1'b0)
    else $error("status bit 5 set");
endmodule

bind eeprom_spi eeprom_spi_sva u_sva (.clk_sys, .rst_n, .chipSelN, .holdN, .serialOutOe,
  .statusReg);

// File: spi_host_model.sv
// Behavioural SPI host driving the link pins of the EEPROM
`timescale 1ns/1ns
module spi_host_model (
  output logic serialClk,
  output logic chipSelN,
  output logic serialIn,
  output logic holdN,
  input wire logic serialOut,
  input wire logic serialOutOe
);
  logic last;
  logic oeSeen;

  // Idle pins, clock stands low
  initial begin
    serialClk = 1'b0;
    chipSelN = 1'b1;
    serialIn = 1'b0;
    holdN = 1'b1;
    last = 1'b0;
  end

  // Notes any output enable within a frame
  always @(posedge serialOutOe) oeSeen = 1'b1;

  // One frame of n bits, MSB first, with optional pause
  task automatic frame(input int n, input logic [63:0] tx, input int holdAt,
    output logic [63:0] rx);
    logic pin;
    #5; // Keeps link edges clear of the system clock edges
    oeSeen = 1'b0;
    chipSelN = 1'b0;
    for (int k = 0; k < n; k++) begin
      serialIn = tx[n-1-k];
      #16;
      if (k == holdAt) begin
        holdN = 1'b0;
        repeat (8) #8 serialIn = ~serialIn;
        holdN = 1'b1;
        #32;
      end
      pin = serialOutOe ? serialOut : ~last; // Released line reads inverted
      last = pin;
      rx = {rx[62:0], pin};
      serialClk = 1'b1;
      #16;
      serialClk = 1'b0;
    end
    #16;
    chipSelN = 1'b1;
    #35;
  endtask
endmodule

// File: serial_eeprom_read_status_hold_tb_top.sv
// Self-checking bench for the serial EEPROM command logic
`timescale 1ns/1ns
module serial_eeprom_read_status_hold_tb_top;
  import eeprom_pkg::*;
  logic clk_sys, rst_n, serialClk, chipSelN, serialIn, holdN, wpN;
  logic fillValid, fillId, serialOut, serialOutOe;
  logic [14:0] fillAddr;
  logic [7:0] fillData, statusReg, st;
  logic [7:0] mem [4];
  logic [7:0] idm [4];
  logic [63:0] rx;
  int fails, tests_run;

  eeprom_spi u_dut (.clk_sys, .rst_n, .serialClk, .chipSelN, .serialIn, .holdN, .wpN,
    .fillValid, .fillId, .fillAddr, .fillData, .serialOut, .serialOutOe, .statusReg);
  spi_host_model u_host (.serialClk, .chipSelN, .serialIn, .holdN, .serialOut, .serialOutOe);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparison, frames and verdict
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic xf(input int n, input logic [63:0] tx, input int holdAt = -1);
    u_host.frame(n, tx, holdAt, rx);
  endtask

  task automatic readStatus(input logic [7:0] exp, input int holdAt = -1);
    xf(16, 64'h0500, holdAt);
    check(rx[7:0], exp);
  endtask

  task automatic writeStatus(input logic [7:0] d);
    xf(8, 64'h06);
    xf(16, {48'h0, 8'h01, d});
  endtask

  // Polls status reads until the busy bit reads clear
  task automatic poll;
    for (int i = 0; i < 40; i++) begin
      xf(16, 64'h0500);
      if (rx[0] === 1'b0) break;
    end
  endtask

  task automatic writeStatusOk(input logic [7:0] d);
    writeStatus(d);
    readStatus(st | 8'h03);
    poll();
    st = d & 8'hDC;
    readStatus(st);
  endtask

  task automatic doReset;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    st = 8'h00;
    check(statusReg, st);
  endtask

  task automatic results;
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #500000;
    fails++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, fillValid, fillId, fillAddr, fillData} <= '0;
    wpN <= 1'b1;
    void'($urandom(32'h7736));
    @(posedge clk_sys);
    doReset();
    readStatus(8'h00);
    xf(7, 64'h03);
    readStatus(8'h00);
    xf(8, 64'h06);
    readStatus(8'h02);
    xf(8, 64'h04);
    readStatus(8'h00);
    xf(16, 64'h018C);
    readStatus(8'h00);
    writeStatusOk(8'($urandom) & 8'hAF);
    readStatus(st, 11);
    writeStatusOk(8'h8C);
    @(posedge clk_sys) wpN <= 1'b0;
    writeStatus(8'h00);
    xf(8, 64'h04);
    readStatus(st);
    @(posedge clk_sys) wpN <= 1'b1;
    fork
      writeStatus(8'h00);
      begin
        repeat (55) @(posedge clk_sys);
        wpN <= 1'b0;
        repeat (5) @(posedge clk_sys);
        wpN <= 1'b1;
      end
    join
    xf(8, 64'h04);
    readStatus(st);
    fork
      writeStatusOk(8'h84);
      begin
        repeat (120) @(posedge clk_sys);
        wpN <= 1'b0;
      end
    join
    @(posedge clk_sys) wpN <= 1'b1;
    writeStatusOk(8'h00);
    @(posedge clk_sys) wpN <= 1'b0;
    writeStatusOk(8'h0C);
    @(posedge clk_sys) wpN <= 1'b1;
    writeStatus(8'h00);
    xf(32, 64'h0300_0000);
    check({7'h0, u_host.oeSeen}, 8'h00);
    poll();
    st = 8'h00;
    readStatus(st);
    xf(24, 64'hFF_0000);
    check({7'h0, u_host.oeSeen}, 8'h00);
    // Load array and id page around their wrap points
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      mem[i] = 8'($urandom);
      idm[i] = 8'($urandom);
      fillValid <= 1'b1;
      fillId <= 1'b0;
      fillAddr <= 15'h7FFE + 15'(i);
      fillData <= mem[i];
      @(posedge clk_sys);
      fillId <= 1'b1;
      fillAddr <= 15'h003E + 15'(i);
      fillData <= idm[i];
      @(posedge clk_sys);
    end
    fillValid <= 1'b0;
    xf(56, {8'h03, 16'hFFFE, 32'h0});
    for (int i = 0; i < 4; i++) check(rx[31-8*i -: 8], mem[i]);
    writeStatusOk(8'h40);
    xf(48, {8'h03, 16'h7FBE, 24'h0});
    for (int i = 0; i < 3; i++) check(rx[23-8*i -: 8], idm[i]);
    st = 8'h00;
    readStatus(st);
    xf(8, 64'h06);
    doReset();
    results();
  end
endmodule
